// File: verilog/ptg_defs.vh
// register map, field positions, reset values and codes of the profile timer
`ifndef PTG_DEFS_VH
`define PTG_DEFS_VH
`define PTG_A_CTRL 8'h00
`define PTG_A_IDLE 8'h04
`define PTG_A_NSECT 8'h08
`define PTG_A_LOOPCNT 8'h0C
`define PTG_A_RESTART 8'h10
`define PTG_A_MONTH 8'h14
`define PTG_A_DAY 8'h18
`define PTG_A_WDAY 8'h1C
`define PTG_A_HOUR 8'h20
`define PTG_A_MIN_LO 8'h24
`define PTG_A_MIN_HI 8'h28
`define PTG_A_SEC_LO 8'h2C
`define PTG_A_SEC_HI 8'h30
`define PTG_A_SSEL 8'h34
`define PTG_A_SCFG 8'h38
`define PTG_A_SFINAL 8'h3C
`define PTG_A_STATUS 8'h40
`define PTG_A_VALUE 8'h44
`define PTG_F_TMODE 2:0
`define PTG_F_LMODE 5:4
`define PTG_F_TSRC 15:8
`define PTG_F_LSRC 23:16
`define PTG_F_DUR 15:0
`define PTG_F_UNIT 17:16
`define PTG_F_SLOPE 18
`define PTG_M_FINAL 31:0
`define PTG_M_DUR 47:32
`define PTG_M_UNIT 49:48
`define PTG_M_SLOPE 50
`define PTG_RST_CTRL 32'h00000000
`define PTG_RST_IDLE 32'h00000000
`define PTG_RST_LOOPCNT 32'h00000001
`define PTG_TM_OFF 3'h0
`define PTG_TM_GATE 3'h1
`define PTG_TM_ONCE 3'h2
`define PTG_TM_RETRIG 3'h3
`define PTG_TM_CAL 3'h4
`define PTG_LM_OFF 2'h0
`define PTG_LM_COUNT 2'h1
`define PTG_LM_CHAN 2'h2
`define PTG_LM_INF 2'h3
`define PTG_U_MIN 2'h1
`define PTG_U_HOUR 2'h2
`define PTG_MULT_SEC 32'h00000001
`define PTG_MULT_MIN 32'h0000003C
`define PTG_MULT_HOUR 32'h00000E10
`define PTG_FRAC 16
`define PTG_DIV_STEPS 6'h31
`define PTG_RESP_OK 2'h0
`define PTG_RESP_ERR 2'h2
`endif

// File: verilog/ptg_sect_mem.v
// section list memory with registered read data
module ptg_sect_mem #(
  parameter DEPTH = 100,
  parameter AW = 7,
  parameter W = 51
) (
  input wire i_clk,
  input wire i_ce,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [W-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [W-1:0] o_rdata
);
  reg [W-1:0] mem [0:DEPTH-1];

  always @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we && i_waddr < DEPTH) begin
        mem[i_waddr] <= i_wdata;
      end
      if (i_raddr < DEPTH) begin
        o_rdata <= mem[i_raddr];
      end else begin
        o_rdata <= {W{1'b0}};
      end
    end
  end
endmodule

// File: verilog/ptg_top.v
// profile timer generator with axi4-lite register slave
//
// Behaviour
// RULE1: five trigger modes; disabled never starts
// RULE2: gate mode runs only while source above zero
// RULE3: one-shot rise starts full uninterrupted run
// RULE4: retrigger rise restarts from first section
// RULE5: trigger source is a selectable channel
// RULE6: output holds idle value when not running
// RULE7: up to 100 sections run in sequence
// RULE8: looping off gives one pass per trigger
// RULE9: counted looping repeats loop-count times
// RULE10: channel looping repeats channel-value times
// RULE11: completed cycles compared with channel value
// RULE12: infinite looping repeats until trigger stops
// RULE13: repeats begin at configurable restart section
// RULE14: calendar mode matches month..second selection sets
// RULE15: one-second resolution, multi-select per field
// RULE16: empty calendar field never starts profile
// RULE17: calendar match acts as one-shot trigger
// RULE18: section has duration, unit, shape, final
// RULE19: repeat ramps from previous final, or steps
// RULE20: evaluate once per tick, edge by compare
`include "ptg_defs.vh"
module ptg_top #(
  parameter NCH = 16,
  parameter TICK_HZ = 10,
  parameter NSECT_MAX = 100
) (
  input wire I_CLK,
  input wire I_RST,
  input wire I_CE,
  input wire I_TICK,
  input wire [NCH*32-1:0] I_CH_VALUES,
  input wire [3:0] I_CAL_MONTH,
  input wire [4:0] I_CAL_DAY,
  input wire [2:0] I_CAL_WDAY,
  input wire [4:0] I_CAL_HOUR,
  input wire [5:0] I_CAL_MIN,
  input wire [5:0] I_CAL_SEC,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  output wire [31:0] O_VALUE,
  output wire O_RUNNING
);
  localparam S_IDLE = 3'd0;
  localparam S_LOAD = 3'd1;
  localparam S_FETCH = 3'd2;
  localparam S_DIV = 3'd3;
  localparam S_RUN = 3'd4;

  reg aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q, rdata_q;
  reg [3:0] w_strb_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] ctrl_q, idle_q, loopcnt_q, sfinal_q;
  reg [7:0] nsect_q, restart_q, ssel_q;
  reg [18:0] scfg_q;
  reg [11:0] m_month_q;
  reg [30:0] m_day_q;
  reg [6:0] m_wday_q;
  reg [23:0] m_hour_q;
  reg [59:0] m_min_q, m_sec_q;
  reg mem_we_q;
  reg [2:0] st_q;
  reg [6:0] idx_q;
  reg [15:0] loops_q;
  reg [31:0] out_q, fin_q, rem_q;
  reg slope_q, src_prev_q, gate_used_q;
  reg [5:0] cal_sec_q, dcnt_q;
  reg signed [49:0] acc_q, step_q;
  reg [48:0] dnum_q;
  reg [32:0] drem_q;
  reg dneg_q;
  wire [50:0] mem_rd;

  function [31:0] merge(input [31:0] old, input [31:0] nw,
                        input [3:0] st);
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) merge[8*k +: 8] = nw[8*k +: 8];
      end
    end
  endfunction

  // axi4-lite handshakes
  assign O_AWREADY = I_CE & ~aw_ok_q & ~bvalid_q;
  assign O_WREADY = I_CE & ~w_ok_q & ~bvalid_q;
  assign O_ARREADY = I_CE & ~rvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_VALUE = out_q;
  assign O_RUNNING = (st_q != S_IDLE);

  wire do_wr = aw_ok_q & w_ok_q & ~bvalid_q;
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {I_ARADDR[7:2], 2'b00};
  wire [31:0] wm_ctrl = merge(ctrl_q, w_data_q, w_strb_q);

  reg wr_hit;
  always @* begin
    case (wa)
      `PTG_A_CTRL, `PTG_A_IDLE, `PTG_A_NSECT, `PTG_A_LOOPCNT,
      `PTG_A_RESTART, `PTG_A_MONTH, `PTG_A_DAY, `PTG_A_WDAY,
      `PTG_A_HOUR, `PTG_A_MIN_LO, `PTG_A_MIN_HI, `PTG_A_SEC_LO,
      `PTG_A_SEC_HI, `PTG_A_SSEL, `PTG_A_SCFG,
      `PTG_A_SFINAL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (ra)
      `PTG_A_CTRL: rd_val = ctrl_q;
      `PTG_A_IDLE: rd_val = idle_q;
      `PTG_A_NSECT: rd_val = {24'h000000, nsect_q};
      `PTG_A_LOOPCNT: rd_val = loopcnt_q;
      `PTG_A_RESTART: rd_val = {24'h000000, restart_q};
      `PTG_A_MONTH: rd_val = {20'h00000, m_month_q};
      `PTG_A_DAY: rd_val = {1'b0, m_day_q};
      `PTG_A_WDAY: rd_val = {25'h0000000, m_wday_q};
      `PTG_A_HOUR: rd_val = {8'h00, m_hour_q};
      `PTG_A_MIN_LO: rd_val = m_min_q[31:0];
      `PTG_A_MIN_HI: rd_val = {4'h0, m_min_q[59:32]};
      `PTG_A_SEC_LO: rd_val = m_sec_q[31:0];
      `PTG_A_SEC_HI: rd_val = {4'h0, m_sec_q[59:32]};
      `PTG_A_SSEL: rd_val = {24'h000000, ssel_q};
      `PTG_A_SCFG: rd_val = {13'h0000, scfg_q};
      `PTG_A_SFINAL: rd_val = sfinal_q;
      `PTG_A_STATUS: rd_val = {loops_q, 1'b0, idx_q, 7'h00, O_RUNNING};
      `PTG_A_VALUE: rd_val = out_q;
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // register slave
  always @(posedge I_CLK) begin
    if (I_RST) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `PTG_RESP_OK;
      rresp_q <= `PTG_RESP_OK;
      rdata_q <= 32'h00000000;
      ctrl_q <= `PTG_RST_CTRL;
      idle_q <= `PTG_RST_IDLE;
      loopcnt_q <= `PTG_RST_LOOPCNT;
      nsect_q <= 8'h00;
      restart_q <= 8'h00;
      ssel_q <= 8'h00;
      scfg_q <= 19'h00000;
      sfinal_q <= 32'h00000000;
      m_month_q <= 12'h000;
      m_day_q <= 31'h00000000;
      m_wday_q <= 7'h00;
      m_hour_q <= 24'h000000;
      m_min_q <= 60'h000000000000000;
      m_sec_q <= 60'h000000000000000;
      mem_we_q <= 1'b0;
    end else if (I_CE) begin
      mem_we_q <= 1'b0;
      if (O_AWREADY && I_AWVALID) begin
        aw_ok_q <= 1'b1;
        aw_addr_q <= I_AWADDR;
      end
      if (O_WREADY && I_WVALID) begin
        w_ok_q <= 1'b1;
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
      end
      if (bvalid_q && I_BREADY) bvalid_q <= 1'b0;
      if (do_wr) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `PTG_RESP_OK : `PTG_RESP_ERR;
        case (wa)
          `PTG_A_CTRL: ctrl_q <= {8'h00, wm_ctrl[23:8], 2'b00,
                                   wm_ctrl[5:4], 1'b0, wm_ctrl[2:0]};
          `PTG_A_IDLE: idle_q <= merge(idle_q, w_data_q, w_strb_q);
          `PTG_A_NSECT: if (w_strb_q[0]) nsect_q <=
            (w_data_q[7:0] > NSECT_MAX) ? NSECT_MAX[7:0] : w_data_q[7:0]; // RULE7
          `PTG_A_LOOPCNT: loopcnt_q <= merge(loopcnt_q, w_data_q, w_strb_q);
          `PTG_A_RESTART: if (w_strb_q[0]) restart_q <= w_data_q[7:0];
          `PTG_A_MONTH: m_month_q <= w_data_q[11:0];
          `PTG_A_DAY: m_day_q <= w_data_q[30:0];
          `PTG_A_WDAY: m_wday_q <= w_data_q[6:0];
          `PTG_A_HOUR: m_hour_q <= w_data_q[23:0];
          `PTG_A_MIN_LO: m_min_q[31:0] <= w_data_q;
          `PTG_A_MIN_HI: m_min_q[59:32] <= w_data_q[27:0];
          `PTG_A_SEC_LO: m_sec_q[31:0] <= w_data_q;
          `PTG_A_SEC_HI: m_sec_q[59:32] <= w_data_q[27:0];
          `PTG_A_SSEL: if (w_strb_q[0]) ssel_q <= w_data_q[7:0];
          `PTG_A_SCFG: scfg_q <= w_data_q[18:0];
          `PTG_A_SFINAL: begin
            sfinal_q <= merge(sfinal_q, w_data_q, w_strb_q);
            mem_we_q <= 1'b1;
          end
          default: ;
        endcase
      end
      if (rvalid_q && I_RREADY) rvalid_q <= 1'b0;
      if (O_ARREADY && I_ARVALID) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_hit ? `PTG_RESP_OK : `PTG_RESP_ERR;
      end
    end
  end

  // section store: {slope, unit, duration, final}
  ptg_sect_mem #(.DEPTH(NSECT_MAX), .AW(7), .W(51)) u_mem (
    .i_clk(I_CLK),
    .i_ce(I_CE),
    .i_we(mem_we_q),
    .i_waddr(ssel_q[6:0]),
    .i_wdata({scfg_q, sfinal_q}),
    .i_raddr(idx_q),
    .o_rdata(mem_rd)
  ); // RULE18

  // trigger and loop source channels
  wire [2:0] tmode = ctrl_q[`PTG_F_TMODE];
  wire [1:0] lmode = ctrl_q[`PTG_F_LMODE];
  wire [7:0] tsrc = ctrl_q[`PTG_F_TSRC];
  wire [7:0] lsrc = ctrl_q[`PTG_F_LSRC];
  wire [31:0] tval = (tsrc < NCH) ? I_CH_VALUES[tsrc*32 +: 32]
                                  : 32'h00000000; // RULE5
  wire signed [31:0] lval = (lsrc < NCH) ? I_CH_VALUES[lsrc*32 +: 32]
                                         : 32'h00000000;
  wire src_hi = ~tval[31] & (|tval);
  wire rise = src_hi & ~src_prev_q; // RULE20

  // calendar match
  wire [11:0] mo_sh = m_month_q >> (I_CAL_MONTH - 4'h1);
  wire [30:0] dy_sh = m_day_q >> (I_CAL_DAY - 5'h01);
  wire [6:0] wd_sh = m_wday_q >> I_CAL_WDAY;
  wire [23:0] hr_sh = m_hour_q >> I_CAL_HOUR;
  wire [59:0] mi_sh = m_min_q >> I_CAL_MIN;
  wire [59:0] se_sh = m_sec_q >> I_CAL_SEC;
  wire cal_sets = (|m_month_q) & (|m_day_q) & (|m_wday_q) &
                  (|m_hour_q) & (|m_min_q) & (|m_sec_q); // RULE16
  wire cal_hit = cal_sets & mo_sh[0] & dy_sh[0] & wd_sh[0] &
                 hr_sh[0] & mi_sh[0] & se_sh[0]; // RULE14
  wire cal_fire = cal_hit & (I_CAL_SEC != cal_sec_q); // RULE15

  wire idle = (st_q == S_IDLE);
  reg start;
  always @* begin
    case (tmode)
      `PTG_TM_GATE: start = src_hi & ~gate_used_q & idle; // RULE2
      `PTG_TM_ONCE: start = rise & idle; // RULE3
      `PTG_TM_RETRIG: start = rise; // RULE4
      `PTG_TM_CAL: start = cal_fire & idle; // RULE17
      default: start = 1'b0; // RULE1
    endcase
  end
  wire go = I_TICK & start & (nsect_q != 8'h00);
  wire stop = I_TICK & ~idle & ((tmode == `PTG_TM_GATE) ? ~src_hi :
              (tmode == `PTG_TM_OFF)); // RULE2

  // section length in ticks
  wire [15:0] m_dur = mem_rd[`PTG_M_DUR];
  wire [1:0] m_unit = mem_rd[`PTG_M_UNIT];
  wire [31:0] mult = (m_unit == `PTG_U_MIN) ? `PTG_MULT_MIN :
                     (m_unit == `PTG_U_HOUR) ? `PTG_MULT_HOUR :
                     `PTG_MULT_SEC;
  wire [31:0] hz = TICK_HZ;
  wire [63:0] lprod = m_dur * mult * hz;
  wire [31:0] len = (lprod[31:0] == 32'h00000000) ? 32'h00000001
                                                  : lprod[31:0];
  wire [31:0] m_fin = mem_rd[`PTG_M_FINAL];
  wire signed [32:0] delta = $signed({m_fin[31], m_fin}) -
                             $signed({out_q[31], out_q});
  wire [32:0] dmag = delta[32] ? (33'h000000000 - delta) : delta;
  wire [33:0] dsh = {drem_q, dnum_q[48]};
  wire dge = dsh >= {2'b00, rem_q};
  wire [33:0] dsub = dsh - {2'b00, rem_q};
  wire signed [49:0] quo = {1'b0, dnum_q};
  wire signed [49:0] acc_n = acc_q + step_q;

  // loop decision at end of a pass
  wire last = ({1'b0, idx_q} + 8'h01) >= nsect_q; // RULE7
  wire [15:0] loops_n = loops_q + 16'h0001;
  reg again;
  always @* begin
    case (lmode)
      `PTG_LM_COUNT: again = {16'h0000, loops_n} < loopcnt_q; // RULE9
      `PTG_LM_CHAN: again = $signed({16'h0000, loops_n}) < lval; // RULE11
      `PTG_LM_INF: again = 1'b1; // RULE12
      default: again = 1'b0; // RULE8
    endcase
  end
  wire [6:0] rst_idx = (restart_q < nsect_q) ? restart_q[6:0] : 7'h00;

  // profile sequencer
  always @(posedge I_CLK) begin
    if (I_RST) begin
      st_q <= S_IDLE;
      idx_q <= 7'h00;
      loops_q <= 16'h0000;
      out_q <= `PTG_RST_IDLE;
      fin_q <= 32'h00000000;
      rem_q <= 32'h00000000;
      slope_q <= 1'b0;
      src_prev_q <= 1'b0;
      gate_used_q <= 1'b0;
      cal_sec_q <= 6'h00;
      acc_q <= 50'h0;
      step_q <= 50'h0;
      dnum_q <= 49'h0;
      drem_q <= 33'h0;
      dneg_q <= 1'b0;
      dcnt_q <= 6'h00;
    end else if (I_CE) begin
      if (I_TICK) begin
        src_prev_q <= src_hi; // RULE20
        cal_sec_q <= I_CAL_SEC;
        if (!src_hi) gate_used_q <= 1'b0;
      end
      if (go) begin
        st_q <= S_LOAD;
        idx_q <= 7'h00; // RULE4
        loops_q <= 16'h0000;
        gate_used_q <= (tmode == `PTG_TM_GATE);
        if (idle) out_q <= idle_q;
      end else if (stop) begin
        st_q <= S_IDLE;
        out_q <= idle_q; // RULE6
      end else begin
        case (st_q)
          S_IDLE: out_q <= idle_q; // RULE6
          S_LOAD: st_q <= S_FETCH;
          S_FETCH: begin
            fin_q <= m_fin;
            slope_q <= mem_rd[`PTG_M_SLOPE];
            rem_q <= len;
            if (mem_rd[`PTG_M_SLOPE]) begin
              acc_q <= {{2{out_q[31]}}, out_q, 16'h0000}; // RULE19
              dnum_q <= {dmag, 16'h0000};
              drem_q <= 33'h0;
              dneg_q <= delta[32];
              dcnt_q <= `PTG_DIV_STEPS;
              st_q <= S_DIV;
            end else begin
              out_q <= m_fin; // RULE19
              st_q <= S_RUN;
            end
          end
          S_DIV: begin
            if (dcnt_q == 6'h00) begin
              step_q <= dneg_q ? -quo : quo;
              st_q <= S_RUN;
            end else begin
              drem_q <= dge ? dsub[32:0] : dsh[32:0];
              dnum_q <= {dnum_q[47:0], dge};
              dcnt_q <= dcnt_q - 6'h01;
            end
          end
          S_RUN: if (I_TICK) begin
            if (rem_q <= 32'h00000001) begin
              out_q <= fin_q;
              if (!last) begin
                idx_q <= idx_q + 7'h01;
                st_q <= S_LOAD;
              end else if (again) begin
                loops_q <= loops_n; // RULE10
                idx_q <= rst_idx; // RULE13
                st_q <= S_LOAD;
              end else begin
                loops_q <= loops_n;
                out_q <= idle_q; // RULE6
                st_q <= S_IDLE;
              end
            end else begin
              rem_q <= rem_q - 32'h00000001;
              if (slope_q) begin
                acc_q <= acc_n;
                out_q <= acc_n[47:16];
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// File: tb/ptg_top_sva.sv
// concurrent checks on the profile timer ports
module ptg_top_sva (
  input wire I_CLK,
  input wire I_RST,
  input wire I_TICK,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire [1:0] O_BRESP,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire [1:0] O_RRESP,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire [31:0] O_VALUE,
  input wire O_RUNNING
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  reg [3:0] since_tick_q;
  wire [3:0] since_tick_d;
  // saturating count of cycles since the last tick
  assign since_tick_d = I_TICK ? 4'h0 : since_tick_q + {3'h0, ~&since_tick_q};
  always @(posedge I_CLK) begin
    since_tick_q <= I_RST ? 4'hF : since_tick_d;
  end
  property p_b_after_aw_w;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> ##1 O_BVALID;
  endproperty
  a_b_after_aw_w: assert property (p_b_after_aw_w)
    else $error("no write response after address and data");
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_drop;
    O_BVALID && I_BREADY |=> !O_BVALID;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response kept");
  property p_r_after_ar;
    I_ARVALID && O_ARREADY |=> O_RVALID;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("no read data");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_aw_refused;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_aw_refused: assert property (p_aw_refused) else $error("write taken early");
  property p_ar_refused;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken early");
  property p_start_on_tick;
    $rose(O_RUNNING) |-> since_tick_q < 4'h4;
  endproperty
  a_start_on_tick: assert property (p_start_on_tick)
    else $error("run started away from a tick");
  property p_idle_hold;
    (!O_RUNNING && !O_BVALID) [*3] |-> $stable(O_VALUE);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("output moved while idle");
  c_write: cover property (O_BVALID && I_BREADY);
  c_read: cover property (O_RVALID && I_RREADY);
  c_run: cover property ($rose(O_RUNNING));
endmodule
bind ptg_top ptg_top_sva ptg_top_sva_inst (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_TICK(I_TICK), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_VALUE(O_VALUE),
  .O_RUNNING(O_RUNNING));

// File: tb/ptg_chan_model.sv
// channel, tick and calendar source model
module ptg_chan_model #(
  parameter NCH = 4,
  parameter TICK_GAP = 64
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ch_we,
  input wire [7:0] i_ch_idx,
  input wire [31:0] i_ch_val,
  output reg o_tick,
  output reg [NCH*32-1:0] o_ch_values,
  output wire [3:0] o_cal_month,
  output wire [4:0] o_cal_day,
  output wire [2:0] o_cal_wday,
  output wire [4:0] o_cal_hour,
  output wire [5:0] o_cal_min,
  output reg [5:0] o_cal_sec
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] gap_q;
  assign o_cal_month = 4'h1;
  assign o_cal_day = 5'h01;
  assign o_cal_wday = 3'h0;
  assign o_cal_hour = 5'h00;
  assign o_cal_min = 6'h00;
  always @(posedge i_clk) begin
    if (i_rst) begin
      gap_q <= 8'h00;
      o_tick <= 1'b0;
      o_cal_sec <= 6'h00;
      o_ch_values <= '0;
    end else begin
      o_tick <= (gap_q == 8'(TICK_GAP - 1));
      gap_q <= (gap_q == 8'(TICK_GAP - 1)) ? 8'h00 : gap_q + 8'h01;
      // one second per tick
      if (o_tick) o_cal_sec <= (o_cal_sec == 6'h3B) ? 6'h00 : o_cal_sec + 6'h01;
      if (i_ch_we) o_ch_values[i_ch_idx*32 +: 32] <= i_ch_val;
    end
  end
endmodule

// File: tb/testbench.sv
// self-checking bench for the profile timer generator
`include "ptg_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] lm;
    logic [7:0] cnt;
    logic [7:0] rs;
    logic [7:0] passes;
  } ptg_row_t;
  localparam [31:0] IDLE = 32'h00000055;
  reg I_CLK = 1'b0;
  reg I_RST = 1'b1;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, ch_we = 1'b0;
  reg ce = 1'b1;
  reg [3:0] wstrb = 4'hF;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, ch_idx = 8'h00;
  reg [31:0] wdata = 32'h00000000, ch_val = 32'h00000000;
  wire tick, awready, wready, bvalid, arready, rvalid, running;
  wire [127:0] chv;
  wire [3:0] mon;
  wire [4:0] day, hour;
  wire [2:0] wday;
  wire [5:0] mins, secs;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, value;
  int err_total = 0;
  int n_checks = 0;
  reg [1:0] resp;
  reg [31:0] rd;
  ptg_row_t rows [0:3];
  always #4 I_CLK = ~I_CLK;
  ptg_chan_model #(.NCH(4), .TICK_GAP(64)) ptg_chan_model_inst (
    .i_clk(I_CLK), .i_rst(I_RST), .i_ch_we(ch_we), .i_ch_idx(ch_idx),
    .i_ch_val(ch_val), .o_tick(tick), .o_ch_values(chv), .o_cal_month(mon),
    .o_cal_day(day), .o_cal_wday(wday), .o_cal_hour(hour), .o_cal_min(mins),
    .o_cal_sec(secs));
  ptg_top #(.NCH(4), .TICK_HZ(1), .NSECT_MAX(100)) ptg_top_inst (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(ce), .I_TICK(tick),
    .I_CH_VALUES(chv), .I_CAL_MONTH(mon), .I_CAL_DAY(day),
    .I_CAL_WDAY(wday), .I_CAL_HOUR(hour), .I_CAL_MIN(mins),
    .I_CAL_SEC(secs), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_VALUE(value), .O_RUNNING(running));
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge I_CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task rdreg(input [7:0] a);
    @(posedge I_CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask
  task setch(input [7:0] i, input [31:0] v);
    @(posedge I_CLK);
    ch_we <= 1'b1;
    ch_idx <= i;
    ch_val <= v;
    @(posedge I_CLK);
    ch_we <= 1'b0;
  endtask
  // lands mid-way between two ticks
  task wait_tick;
    @(posedge I_CLK);
    while (!tick) @(posedge I_CLK);
    repeat (32) @(posedge I_CLK);
  endtask
  function [31:0] ctrl(input [2:0] tm, input [1:0] lm);
    return {8'h00, 8'h02, 8'h01, 2'h0, lm, 1'b0, tm};
  endfunction
  // sections: 11 for 1 s, 22 for 2 s, 33 for 1 s
  function automatic [31:0] expv(input int k, input int passes, input int rs);
    int ss, len;
    ss = (rs == 0) ? 0 : (rs == 1) ? 1 : 3;
    len = 4 - ss;
    if (k >= 4 + (passes - 1) * len) return IDLE;
    if (k >= 4) k = ss + (k - 4) % len;
    if (k == 0) return 32'h00000011;
    if (k == 3) return 32'h00000033;
    return 32'h00000022;
  endfunction
  initial begin
    rows[0] = '{`PTG_LM_OFF, 8'h01, 8'h00, 8'h01};
    rows[1] = '{`PTG_LM_COUNT, 8'h02, 8'h01, 8'h02};
    rows[2] = '{`PTG_LM_CHAN, 8'h03, 8'h02, 8'h03};
    rows[3] = '{`PTG_LM_CHAN, 8'h00, 8'h01, 8'h01};
    repeat (16) @(posedge I_CLK);
    I_RST <= 1'b0;
    chk({31'h0, running}, 32'h0);
    rdreg(`PTG_A_LOOPCNT);
    chk(rd, `PTG_RST_LOOPCNT);
    rdreg(`PTG_A_CTRL);
    chk(rd, `PTG_RST_CTRL);
    rdreg(8'h7C);
    chk({30'h0, resp}, {30'h0, `PTG_RESP_ERR});
    wr(8'h7C, 32'hFFFFFFFF);
    chk({30'h0, resp}, {30'h0, `PTG_RESP_ERR});
    for (int s = 0; s < 3; s++) begin
      wr(`PTG_A_SSEL, 32'(s));
      wr(`PTG_A_SCFG, (s == 1) ? 32'h00000002 : 32'h00000001);
      wr(`PTG_A_SFINAL, 32'(17 * (s + 1)));
    end
    wr(`PTG_A_NSECT, 32'h00000003);
    // only the low byte is enabled, so the upper bytes stay zero
    wstrb <= 4'h1;
    wr(`PTG_A_IDLE, 32'hAAAAAA55);
    wstrb <= 4'hF;
    rdreg(`PTG_A_IDLE);
    chk(rd, IDLE);
    repeat (4) @(posedge I_CLK);
    chk(value, IDLE);
    for (int r = 0; r < 4; r++) begin
      wr(`PTG_A_CTRL, ctrl(`PTG_TM_ONCE, rows[r].lm));
      wr(`PTG_A_LOOPCNT, (rows[r].lm == `PTG_LM_COUNT) ? 32'(rows[r].cnt) : 5);
      wr(`PTG_A_RESTART, {24'h0, rows[r].rs});
      setch(8'h02, {24'h0, rows[r].cnt});
      setch(8'h01, 32'h0);
      wait_tick;
      setch(8'h01, 32'h1);
      for (int k = 0; k < 9; k++) begin
        wait_tick;
        chk(value, expv(k, rows[r].passes, rows[r].rs));
        if (k == 0) setch(8'h01, 32'h0);
      end
    end
    wr(`PTG_A_CTRL, ctrl(`PTG_TM_OFF, `PTG_LM_OFF));
    wait_tick;
    setch(8'h01, 32'h1);
    repeat (2) begin
      wait_tick;
      chk({31'h0, running}, 32'h0);
    end
    setch(8'h01, 32'hFFFFFFFF);
    wr(`PTG_A_CTRL, ctrl(`PTG_TM_GATE, `PTG_LM_INF));
    wr(`PTG_A_RESTART, 32'h0);
    wait_tick;
    chk({31'h0, running}, 32'h0);
    setch(8'h01, 32'h1);
    for (int k = 0; k < 6; k++) begin
      wait_tick;
      chk(value, expv(k, 100, 0));
    end
    setch(8'h01, 32'h0);
    wait_tick;
    chk(value, IDLE);
    wr(`PTG_A_CTRL, ctrl(`PTG_TM_RETRIG, `PTG_LM_OFF));
    wait_tick;
    setch(8'h01, 32'h1);
    wait_tick;
    setch(8'h01, 32'h0);
    wait_tick;
    chk(value, 32'h00000022);
    setch(8'h01, 32'h1);
    for (int k = 0; k < 5; k++) begin
      wait_tick;
      chk(value, expv(k, 1, 0));
    end
    setch(8'h01, 32'h0);
    for (int a = 8'h14; a <= 8'h30; a += 4) wr(8'(a), 32'hFFFFFFFF);
    wr(`PTG_A_CTRL, ctrl(`PTG_TM_CAL, `PTG_LM_OFF));
    wait_tick;
    chk({31'h0, running}, 32'h1);
    wr(`PTG_A_MONTH, 32'h0);
    repeat (6) wait_tick;
    chk({31'h0, running}, 32'h0);
    chk(value, IDLE);
    // section 1 becomes a ramp from 11 to 22 over two ticks
    wr(`PTG_A_SSEL, 32'h00000001);
    wr(`PTG_A_SCFG, 32'h00040002);
    wr(`PTG_A_SFINAL, 32'h00000022);
    wr(`PTG_A_CTRL, ctrl(`PTG_TM_ONCE, `PTG_LM_OFF));
    // clock enable low: the rising source and the tick are not seen
    ce <= 1'b0;
    setch(8'h01, 32'h1);
    wait_tick;
    chk({31'h0, running}, 32'h0);
    chk({31'h0, awready}, 32'h0);
    ce <= 1'b1;
    wait_tick;
    chk({31'h0, running}, 32'h1);
    chk(value, 32'h00000011);
    wait_tick;
    chk(value, 32'h00000011);
    wait_tick;
    chk(value, 32'h00000019);
    wait_tick;
    chk(value, 32'h00000033);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    err_total++;
    conclude;
  end
endmodule
